/* File: logic/pwm_steer_pkg.sv */
/*
 * Constants for the restart, dead-band and steering output stage:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 50 MHz aclk and an instruction cycle of 200 ns.
 */
`default_nettype none

package pwm_steer_pkg;

	// Register byte offsets
	localparam logic [4:0] OFF_PWM_CTRL   = 5'h00;
	localparam logic [4:0] OFF_STEER_CTRL = 5'h04;
	localparam logic [4:0] OFF_SHUTDOWN   = 5'h08;
	localparam logic [4:0] OFF_IRQ_STATUS = 5'h0c;
	localparam logic [4:0] OFF_IRQ_MASK   = 5'h10;

	// Register indices
	localparam logic [2:0] IDX_PWM_CTRL   = 3'h0;
	localparam logic [2:0] IDX_STEER_CTRL = 3'h1;
	localparam logic [2:0] IDX_SHUTDOWN   = 3'h2;
	localparam logic [2:0] IDX_IRQ_STATUS = 3'h3;
	localparam logic [2:0] IDX_IRQ_MASK   = 3'h4;
	localparam logic [2:0] IDX_NONE       = 3'h7;

	// Field positions
	localparam int AUTO_RESTART_BIT = 7;
	localparam int DB_COUNT_W       = 7;
	localparam int STEER_SYNC_BIT   = 4;
	localparam int STEER_W          = 5;
	localparam int SHUT_FLAG_BIT    = 0;
	localparam int IRQ_SHUT_BIT     = 0;
	localparam int IRQ_RESUME_BIT   = 1;
	localparam int IRQ_W            = 2;

	// Reset values
	localparam logic [7:0]         PWM_CTRL_RESET   = 8'h00;
	localparam logic [STEER_W-1:0] STEER_CTRL_RESET = 5'h01;
	localparam logic [IRQ_W-1:0]   IRQ_MASK_RESET   = 2'h0;

	// Mode encodings
	localparam logic [1:0] CCP_PWM_MODE    = 2'h3;
	localparam logic [1:0] CFG_SINGLE      = 2'h0;
	localparam logic [1:0] CFG_HALF_BRIDGE = 2'h2;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing: one dead-band count is one instruction cycle
	localparam int CLK_PERIOD_NS = 20;
	localparam int TCY_NS        = 200;
	localparam int TCY_CYCLES    = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DB_CYC_W      = 11;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_SHUT = 2'b01,
		ST_ARM  = 2'b10
	} run_state_t;

endpackage

`default_nettype wire

/* File: logic/deadband_if.sv */
/*
 * Connection between the output stage and one dead-band delay channel.
 * Assumes both ends run on the same aclk.
 */
`timescale 1ns/1ps
`default_nettype none

interface deadband_if;
	import pwm_steer_pkg::*;
	logic                  active_in;
	logic [DB_COUNT_W-1:0] delay_count;
	logic                  active_out;

	modport owner (output active_in, output delay_count, input active_out);
	modport delay (input active_in, input delay_count, output active_out);
endinterface

`default_nettype wire

/* File: logic/deadband_delay.sv */
/*
 * One dead-band channel: delays inactive-to-active edges, passes the
 * active-to-inactive edges at once.
 * Assumes active_in is synchronous to aclk.
 */
`timescale 1ns/1ps
`default_nettype none

module deadband_delay (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	deadband_if.delay       db
);
	import pwm_steer_pkg::*;

	logic                active_q_reg;
	logic                waiting_reg;
	logic [DB_CYC_W-1:0] cnt_reg;
	logic                out_reg;
	logic [DB_CYC_W-1:0] load_cycles;

	assign load_cycles = DB_CYC_W'(db.delay_count * TCY_CYCLES);
	assign db.active_out = out_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_q_reg <= 1'b0;
		end else begin
			active_q_reg <= db.active_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			waiting_reg <= 1'b0;
			cnt_reg     <= '0;
			out_reg     <= 1'b0;
		end else if (!db.active_in) begin
			waiting_reg <= 1'b0;
			out_reg     <= 1'b0;
		end else if (!active_q_reg) begin
			if (load_cycles == '0) begin
				out_reg <= 1'b1;
			end else begin
				waiting_reg <= 1'b1;
				cnt_reg     <= load_cycles - DB_CYC_W'(1);
			end
		end else if (waiting_reg) begin
			if (cnt_reg == '0) begin
				waiting_reg <= 1'b0;
				out_reg     <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg - DB_CYC_W'(1);
			end
		end
	end

endmodule

`default_nettype wire

/* File: logic/pwm_restart_deadband_steering.sv */
/*
 * Enhanced PWM output stage: auto-restart after shutdown, half-bridge
 * dead-band and single-output pulse steering, with an AXI4-Lite slave.
 * Assumes a PWM waveform and period-start pulse on aclk, and an
 * asynchronous shutdown level.
 */
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pwm_restart_deadband_steering (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        pwm_in,
	input  wire logic        period_start,
	input  wire logic        shutdown_level,
	input  wire logic [1:0]  ccp_mode_upper_bits,
	input  wire logic [1:0]  output_polarity_bits,
	input  wire logic [1:0]  output_configuration_field,
	input  wire logic [1:0]  shutdown_state_ac,
	input  wire logic [1:0]  shutdown_state_bd,
	output logic             pwm_output_a,
	output logic             pwm_output_b,
	output logic             pwm_output_c,
	output logic             pwm_output_d,
	output logic             pwm_drive_a,
	output logic             pwm_drive_b,
	output logic             pwm_drive_c,
	output logic             pwm_drive_d,
	output logic             irq
);
	import pwm_steer_pkg::*;

	function automatic logic [2:0] reg_index(input logic [4:0] addr);
		case (addr)
			OFF_PWM_CTRL:   reg_index = IDX_PWM_CTRL;
			OFF_STEER_CTRL: reg_index = IDX_STEER_CTRL;
			OFF_SHUTDOWN:   reg_index = IDX_SHUTDOWN;
			OFF_IRQ_STATUS: reg_index = IDX_IRQ_STATUS;
			OFF_IRQ_MASK:   reg_index = IDX_IRQ_MASK;
			default:        reg_index = IDX_NONE;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers and state

	logic [7:0]         pwm_ctrl_reg;
	logic [STEER_W-1:0] steer_ctrl_reg;
	logic [3:0]         steer_active_reg;
	logic               steer_pending_reg;
	logic               shutdown_event_flag_reg;
	logic [IRQ_W-1:0]   irq_status_reg;
	logic [IRQ_W-1:0]   irq_mask_reg;
	run_state_t         state_reg;
	run_state_t         state_next;
	logic               shut_meta_reg;
	logic               shut_sync_reg;
	logic               aw_hold_reg;
	logic [4:0]         aw_addr_reg;
	logic               w_hold_reg;
	logic [31:0]        w_data_reg;
	logic [3:0]         w_steer_enable_pin_b_reg;
	logic [3:0]         pin_level_reg;
	logic [3:0]         pin_drive_reg;
	logic               do_write;
	logic [2:0]         wr_idx;
	logic               wr_byte0;
	logic               auto_restart_enable;
	logic               steering_sync_select;
	logic               steer_mode;
	logic               half_bridge;
	logic               in_shutdown;
	logic [IRQ_W-1:0]   irq_set;
	logic [1:0]         db_out;

	assign auto_restart_enable  = pwm_ctrl_reg[AUTO_RESTART_BIT];
	assign steering_sync_select = steer_ctrl_reg[STEER_SYNC_BIT];
	assign steer_mode  = (ccp_mode_upper_bits == CCP_PWM_MODE) &&
	                     (output_configuration_field == CFG_SINGLE);
	assign half_bridge = (ccp_mode_upper_bits == CCP_PWM_MODE) &&
	                     (output_configuration_field == CFG_HALF_BRIDGE);
	assign in_shutdown = (state_reg != ST_RUN);

	////////////////////////////////////////////////////////////////////////////
	// Shutdown level synchroniser

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shut_meta_reg <= 1'b0;
			shut_sync_reg <= 1'b0;
		end else begin
			shut_meta_reg <= shutdown_level;
			shut_sync_reg <= shut_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel

	assign s_axi_awready = !aw_hold_reg;
	assign s_axi_wready  = !w_hold_reg;
	assign do_write      = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign wr_idx        = reg_index(aw_addr_reg);
	assign wr_byte0      = do_write && w_steer_enable_pin_b_reg[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg  <= 1'b0;
			aw_addr_reg  <= '0;
			w_hold_reg   <= 1'b0;
			w_data_reg   <= '0;
			w_steer_enable_pin_b_reg   <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_hold_reg) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold_reg) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_steer_enable_pin_b_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			case (reg_index(s_axi_araddr))
				IDX_PWM_CTRL:   s_axi_rdata <= {24'h000000, pwm_ctrl_reg};
				IDX_STEER_CTRL: s_axi_rdata <= {27'h0000000, steer_ctrl_reg};
				IDX_SHUTDOWN:   s_axi_rdata <= {31'h00000000, shutdown_event_flag_reg};
				IDX_IRQ_STATUS: s_axi_rdata <= {30'h00000000, irq_status_reg};
				IDX_IRQ_MASK:   s_axi_rdata <= {30'h00000000, irq_mask_reg};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwm_ctrl_reg <= PWM_CTRL_RESET;
		end else if (wr_byte0 && wr_idx == IDX_PWM_CTRL) begin
			pwm_ctrl_reg <= w_data_reg[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			steer_ctrl_reg <= STEER_CTRL_RESET;
		end else if (wr_byte0 && wr_idx == IDX_STEER_CTRL) begin
			steer_ctrl_reg <= w_data_reg[STEER_W-1:0];
		end
	end

	// Steering selection actually on the pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			steer_active_reg  <= STEER_CTRL_RESET[3:0];
			steer_pending_reg <= 1'b0;
		end else if (wr_byte0 && wr_idx == IDX_STEER_CTRL) begin
			if (w_data_reg[STEER_SYNC_BIT]) begin
				steer_pending_reg <= 1'b1;
			end else begin
				steer_active_reg  <= w_data_reg[3:0];
				steer_pending_reg <= 1'b0;
			end
		end else if (steer_pending_reg && period_start) begin
			steer_active_reg  <= steer_ctrl_reg[3:0];
			steer_pending_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shutdown flag and restart sequence

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shutdown_event_flag_reg <= 1'b0;
		end else if (shut_sync_reg) begin
			shutdown_event_flag_reg <= 1'b1;
		end else if (auto_restart_enable) begin
			shutdown_event_flag_reg <= 1'b0;
		end else if (wr_byte0 && wr_idx == IDX_SHUTDOWN) begin
			shutdown_event_flag_reg <= w_data_reg[SHUT_FLAG_BIT];
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (shutdown_event_flag_reg || shut_sync_reg) begin
					state_next = ST_SHUT;
				end
			end
			ST_SHUT: begin
				if (!shutdown_event_flag_reg && !shut_sync_reg) begin
					state_next = ST_ARM;
				end
			end
			ST_ARM: begin
				if (shutdown_event_flag_reg || shut_sync_reg) begin
					state_next = ST_SHUT;
				end else if (period_start) begin
					state_next = ST_RUN;
				end
			end
			default: state_next = ST_SHUT;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupts

	assign irq_set[IRQ_SHUT_BIT]   = (state_reg == ST_RUN) && (state_next == ST_SHUT);
	assign irq_set[IRQ_RESUME_BIT] = (state_reg == ST_ARM) && (state_next == ST_RUN);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_reg <= '0;
		end else if (wr_byte0 && wr_idx == IDX_IRQ_STATUS) begin
			irq_status_reg <= (irq_status_reg & ~w_data_reg[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_status_reg <= irq_status_reg | irq_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_reg <= IRQ_MASK_RESET;
		end else if (wr_byte0 && wr_idx == IDX_IRQ_MASK) begin
			irq_mask_reg <= w_data_reg[IRQ_W-1:0];
		end
	end

	assign irq = |(irq_status_reg & irq_mask_reg);

	////////////////////////////////////////////////////////////////////////////
	// Half-bridge dead-band channels

	deadband_if db_link[2] ();

	assign db_link[0].active_in   = pwm_in;
	assign db_link[0].delay_count = pwm_ctrl_reg[DB_COUNT_W-1:0];
	assign db_link[1].active_in   = !pwm_in;
	assign db_link[1].delay_count = pwm_ctrl_reg[DB_COUNT_W-1:0];
	assign db_out[0] = db_link[0].active_out;
	assign db_out[1] = db_link[1].active_out;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_db
			deadband_delay u_db (
				.aclk    (aclk),
				.aresetn (aresetn),
				.db      (db_link[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Output pins

	generate
		for (g = 0; g < 4; g++) begin : g_pin
			logic       en;
			logic       wave;
			logic       act_low;
			logic [1:0] shut_sel;

			always_comb begin
				if (steer_mode) begin
					en   = steer_active_reg[g];
					wave = pwm_in;
				end else if (half_bridge) begin
					en   = (g < 2);
					wave = (g < 2) ? db_out[g % 2] : 1'b0;
				end else begin
					en   = (g == 0);
					wave = (g == 0) ? pwm_in : 1'b0;
				end
			end

			assign act_low  = (g % 2 == 0) ? output_polarity_bits[1] : output_polarity_bits[0];
			assign shut_sel = (g % 2 == 0) ? shutdown_state_ac : shutdown_state_bd;

			// Driver enable comes only from the pin enable and the shutdown state
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pin_level_reg[g] <= 1'b0;
					pin_drive_reg[g] <= 1'b0;
				end else if (!en) begin
					pin_level_reg[g] <= 1'b0;
					pin_drive_reg[g] <= 1'b0;
				end else if (in_shutdown) begin
					pin_level_reg[g] <= shut_sel[0];
					pin_drive_reg[g] <= !shut_sel[1];
				end else begin
					pin_level_reg[g] <= wave ^ act_low;
					pin_drive_reg[g] <= 1'b1;
				end
			end
		end
	endgenerate

	assign pwm_output_a = pin_level_reg[0];
	assign pwm_output_b = pin_level_reg[1];
	assign pwm_output_c = pin_level_reg[2];
	assign pwm_output_d = pin_level_reg[3];
	assign pwm_drive_a  = pin_drive_reg[0];
	assign pwm_drive_b  = pin_drive_reg[1];
	assign pwm_drive_c  = pin_drive_reg[2];
	assign pwm_drive_d  = pin_drive_reg[3];

endmodule

`default_nettype wire

/* File: tb/bridge_switch_model.sv */
/*
 * Far side model: the gate drivers of the power switches.
 * Assumes one pin level and one drive enable per output pin.
 */
`timescale 1ns/1ps
`default_nettype none

module bridge_switch_model (
	input  wire logic [3:0] level,
	input  wire logic [3:0] drive,
	output logic      [3:0] pad
);
	// Released pins are pulled low by the gate resistors
	assign pad = level & drive;
endmodule

`default_nettype wire

/* File: tb/pwm_steer_checker_assertions.sv */
/*
 * Port checker for the restart, dead-band and steering stage.
 * Assumes the ports of pwm_restart_deadband_steering, bound below.
 */
`timescale 1ns/1ps
`default_nettype none

module pwm_steer_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        pwm_in,
	input wire logic        shutdown_level,
	input wire logic [1:0]  ccp_mode_upper_bits,
	input wire logic [1:0]  output_polarity_bits,
	input wire logic [1:0]  output_configuration_field,
	input wire logic [1:0]  shutdown_state_ac,
	input wire logic        pwm_output_a,
	input wire logic        pwm_output_c,
	input wire logic        pwm_drive_a,
	input wire logic        pwm_drive_b,
	input wire logic        pwm_drive_c,
	input wire logic        pwm_drive_d
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////////////
	// Bus
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid) else $error("write answer missing");
	chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
	chk_read_gate: assert property (s_axi_arready != s_axi_rvalid) else $error("read gate wrong");

	////////////////////////////////////////////////////////////////////////////////
	// Pins
	chk_steer_a_path: assert property (
		(ccp_mode_upper_bits == 2'h3 && output_configuration_field == 2'h0)[*2] ##0 pwm_drive_a
		|-> pwm_output_a == ($past(pwm_in) ^ $past(output_polarity_bits[1]))
		|| pwm_output_a == (shutdown_state_ac == 2'h1)) else $error("pin a path wrong");
	chk_other_modes_off: assert property (
		(!(ccp_mode_upper_bits == 2'h3 && output_configuration_field == 2'h0))[*2]
		|-> !pwm_drive_c && !pwm_drive_d) else $error("pins c d driven outside steering");
	chk_fall_prompt: assert property (
		(ccp_mode_upper_bits == 2'h3 && output_configuration_field == 2'h2)[*4] ##0 $fell(pwm_in)
		&& shutdown_state_ac != 2'h1 |-> ##[1:3] !pwm_output_a) else $error("falling edge delayed");
	chk_shutdown_hold: assert property (
		shutdown_level[*5] ##0 pwm_drive_c && shutdown_state_ac == 2'h1 |-> pwm_output_c)
		else $error("shutdown state missing");
endmodule

bind pwm_restart_deadband_steering pwm_steer_checker chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_in, .shutdown_level, .ccp_mode_upper_bits,
	.output_polarity_bits, .output_configuration_field, .shutdown_state_ac, .pwm_output_a, .pwm_output_c,
	.pwm_drive_a, .pwm_drive_b, .pwm_drive_c, .pwm_drive_d);

`default_nettype wire

/* File: tb/pwm_restart_deadband_steering_tb.sv */
/*
 * Testbench: register sequences over AXI4-Lite with expected values.
 * Assumes the design package and the switch model.
 */
`timescale 1ns/1ps
`default_nettype none

module pwm_restart_deadband_steering_tb;
	import pwm_steer_pkg::*;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [4:0]  awaddr = 5'h00;
	logic [4:0]  araddr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp;
	logic        pwm_in = 1'h0, period_start = 1'h0, shut = 1'h0;
	logic [1:0]  upper = 2'h3, pol = 2'h0, cfg = 2'h0, shs = 2'h1;
	logic [3:0]  lvl, drv, pad, e;
	int          miscompares = 0, checked = 0, cycles = 0, n, t;

	always #10 aclk = ~aclk;

	pwm_restart_deadband_steering uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_in(pwm_in), .period_start(period_start),
		.shutdown_level(shut), .ccp_mode_upper_bits(upper), .output_polarity_bits(pol),
		.output_configuration_field(cfg), .shutdown_state_ac(shs), .shutdown_state_bd(shs),
		.pwm_output_a(lvl[0]), .pwm_output_b(lvl[1]), .pwm_output_c(lvl[2]), .pwm_output_d(lvl[3]),
		.pwm_drive_a(drv[0]), .pwm_drive_b(drv[1]), .pwm_drive_c(drv[2]), .pwm_drive_d(drv[3]), .irq(irq));

	bridge_switch_model sw (.level(lvl), .drive(drv), .pad(pad));

	////////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		aw = 1'h1;
		w = 1'h1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && awready) begin
				aw = 1'h0;
				awvalid <= 1'h0;
			end
			if (w && wready) begin
				w = 1'h0;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'h1);
		bready <= 1'h0;
		cmp_word({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		rready <= 1'h0;
		cmp_word(rdata, exp);
		cmp_word({30'h0, rresp}, {30'h0, er});
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask

	task automatic period_pulse;
		@(posedge aclk);
		period_start <= 1'h1;
		@(posedge aclk);
		period_start <= 1'h0;
	endtask

	task close_out;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequence
	initial begin
		cyc(20);
		aresetn <= 1'h1;
		rd(OFF_PWM_CTRL, 32'h0, RESP_OKAY);
		rd(OFF_STEER_CTRL, 32'h1, RESP_OKAY);
		rd(OFF_SHUTDOWN, 32'h0, RESP_OKAY);
		rd(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
		rd(5'h14, 32'h0, RESP_SLVERR);
		wr(5'h18, 32'hff, RESP_SLVERR);
		wr(OFF_STEER_CTRL, 32'hff, RESP_OKAY);
		rd(OFF_STEER_CTRL, 32'h1f, RESP_OKAY);
		for (int i = 0; i < 16; i++) begin
			pol <= i[2:1];
			pwm_in <= i[0];
			wr(OFF_STEER_CTRL, 32'(i), RESP_OKAY);
			cyc(2);
			e = {pwm_in ^ pol[0], pwm_in ^ pol[1], pwm_in ^ pol[0], pwm_in ^ pol[1]} & 4'(i);
			cmp_word({28'h0, drv}, 32'(i));
			cmp_word({28'h0, pad}, {28'h0, e});
		end
		pol <= 2'h0;
		pwm_in <= 1'h0;
		for (int m = 0; m < 3; m++) begin
			{upper, cfg} <= (m == 0) ? 4'h0 : (m == 1) ? 4'hd : 4'hf;
			cyc(3);
			cmp_word({28'h0, drv}, 32'h1);
		end
		{upper, cfg} <= 4'hc;
		wr(OFF_STEER_CTRL, 32'h1, RESP_OKAY);
		wr(OFF_STEER_CTRL, 32'h12, RESP_OKAY);
		rd(OFF_STEER_CTRL, 32'h12, RESP_OKAY);
		cmp_word({28'h0, drv}, 32'h1);
		period_pulse();
		cyc(2);
		cmp_word({28'h0, drv}, 32'h2);
		wr(OFF_STEER_CTRL, 32'h4, RESP_OKAY);
		shut <= 1'h1;
		cyc(6);
		cmp_word({28'h0, pad}, 32'h4);
		cmp_word({31'h0, irq}, 32'h0);
		wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
		cyc(1);
		cmp_word({31'h0, irq}, 32'h1);
		rd(OFF_SHUTDOWN, 32'h1, RESP_OKAY);
		wr(OFF_SHUTDOWN, 32'h0, RESP_OKAY);
		rd(OFF_SHUTDOWN, 32'h1, RESP_OKAY);
		shut <= 1'h0;
		cyc(6);
		rd(OFF_SHUTDOWN, 32'h1, RESP_OKAY);
		cmp_word({28'h0, pad}, 32'h4);
		wr(OFF_SHUTDOWN, 32'h0, RESP_OKAY);
		cyc(3);
		cmp_word({28'h0, pad}, 32'h4);
		period_pulse();
		cyc(3);
		cmp_word({28'h0, pad}, 32'h0);
		wr(OFF_IRQ_STATUS, 32'h3, RESP_OKAY);
		rd(OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
		cmp_word({31'h0, irq}, 32'h0);
		shs <= 2'h2;
		wr(OFF_PWM_CTRL, 32'h80, RESP_OKAY);
		shut <= 1'h1;
		cyc(6);
		rd(OFF_SHUTDOWN, 32'h1, RESP_OKAY);
		cmp_word({28'h0, drv}, 32'h0);
		shut <= 1'h0;
		cyc(4);
		rd(OFF_SHUTDOWN, 32'h0, RESP_OKAY);
		period_pulse();
		cyc(3);
		cmp_word({28'h0, pad}, 32'h0);
		{upper, cfg} <= 4'he;
		for (int k = 0; k < 2; k++) begin
			n = k * 5;
			wr(OFF_PWM_CTRL, 32'(n), RESP_OKAY);
			cyc(60);
			pwm_in <= 1'h1;
			t = 0;
			do begin
				@(posedge aclk);
				t++;
			end while (pad[0] !== 1'h1 && t < 300);
			cmp_word(32'(t >= n * TCY_CYCLES && t <= n * TCY_CYCLES + 4), 32'h1);
			cmp_word({31'h0, pad[1]}, 32'h0);
			pwm_in <= 1'h0;
			cyc(4);
			cmp_word({30'h0, pad[1:0]}, {30'h0, (n == 0), 1'h0});
		end
		close_out();
	end
endmodule

`default_nettype wire
